//--- core/pixsel_pkg.sv
// Constants and types shared by the palette access and pixel select logic
package pixsel_pkg;

    // Pixel group layout: {sync_n, blank_n, overlay[9:0], index[39:0]}
    localparam int GROUP_PIX  = 5;
    localparam int PIX_W      = 8;
    localparam int OVL_W      = 2;
    localparam int GRP_OVL_LO = GROUP_PIX * PIX_W;
    localparam int GRP_BLANK  = GRP_OVL_LO + GROUP_PIX * OVL_W;
    localparam int GRP_SYNC   = GRP_BLANK + 1;
    localparam int GRP_W      = GRP_SYNC + 1;

    // APB byte offsets; bits [3:2] act as the target select pair
    localparam logic [11:0] OFS_POINTER = 12'h000;
    localparam logic [11:0] OFS_PALETTE = 12'h004;
    localparam logic [11:0] OFS_CONTROL = 12'h008;
    localparam logic [11:0] OFS_OVERLAY = 12'h00c;
    localparam logic [11:0] OFS_CONFIG  = 12'h010;

    // Target select codes {target_sel_hi, target_sel_lo}
    localparam logic [1:0] TGT_POINTER = 2'h0;
    localparam logic [1:0] TGT_PALETTE = 2'h1;
    localparam logic [1:0] TGT_CONTROL = 2'h2;
    localparam logic [1:0] TGT_OVERLAY = 2'h3;

    // Pointer values of interest
    localparam logic [7:0] PTR_OVL_LAST  = 8'h03;
    localparam logic [7:0] PTR_OVL_AFTER = 8'h04;
    localparam logic [7:0] PTR_PAL_LAST  = 8'hff;
    localparam logic [7:0] PTR_PAL_FIRST = 8'h00;

    // Command register bit positions
    localparam int CMD_MUX5     = 7;
    localparam int CMD_PAL_EN   = 6;
    localparam int CMD_RATE_LO  = 4;
    localparam int CMD_OL_BLINK = 2;
    localparam int CMD_OL_EN    = 0;

    // Channel modes and color identities
    typedef enum logic [1:0] {
        MODE_TRIPLE   = 2'h0,
        MODE_NORMAL   = 2'h1,
        MODE_PERCOLOR = 2'h2
    } mode_e;
    localparam logic [1:0] CNT_RED  = 2'h0;
    localparam logic [1:0] CNT_BLUE = 2'h2;

    // Values after reset
    localparam logic [7:0] RST_CMD   = 8'h43;
    localparam logic [7:0] RST_RMASK = 8'hff;
    localparam logic [3:0] RST_CFG   = 4'h0;

    // Retrace load count and group cycle counts
    localparam int         RETRACE_LOADS_DEF = 256;
    localparam logic [2:0] GROUP_4_CYCLES    = 3'h4;
    localparam logic [2:0] GROUP_5_CYCLES    = 3'h5;

endpackage : pixsel_pkg

//--- core/color_mem_if.sv
// Interface between the access logic and the color store
`timescale 1ns/1ps
interface color_mem_if;
    logic        we;       // Write strobe
    logic        ovl;      // Overlay table selected
    logic [2:0]  wmask;    // Byte lanes {red, green, blue}
    logic [7:0]  addr;     // Host entry address
    logic [23:0] wdata;    // Host write word
    logic [23:0] hdata;    // Host read word
    logic [7:0]  pix_idx;  // Display palette index
    logic [1:0]  ovl_idx;  // Display overlay index
    logic [23:0] pix_data; // Display palette word
    logic [23:0] ovl_data; // Display overlay word

    modport ctrl  (output we, ovl, wmask, addr, wdata, pix_idx, ovl_idx,
                   input hdata, pix_data, ovl_data);
    modport store (input we, ovl, wmask, addr, wdata, pix_idx, ovl_idx,
                   output hdata, pix_data, ovl_data);
endinterface : color_mem_if

//--- core/color_store.sv
// Dual-port palette and overlay store, one palette array and one overlay array per byte lane
`timescale 1ns/1ps
module color_store
(
    input wire logic   clk, // Pixel clock
    color_mem_if.store m    // Access and display ports
);

    // *******************************
    // Lane storage
    // *******************************
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_lane
            logic [7:0] pal [256];
            logic [7:0] ovl [4];

            // Host write, one lane
            always_ff @(posedge clk)
            begin
                if (m.we && m.wmask[g])
                begin
                    if (m.ovl)
                        ovl[m.addr[1:0]] <= m.wdata[8*g +: 8];
                    else
                        pal[m.addr] <= m.wdata[8*g +: 8];
                end
            end

            // Reads for host and display
            assign m.hdata[8*g +: 8]    = m.ovl ? ovl[m.addr[1:0]] : pal[m.addr];
            assign m.pix_data[8*g +: 8] = pal[m.pix_idx];
            assign m.ovl_data[8*g +: 8] = ovl[m.ovl_idx];
        end
    endgenerate

endmodule : color_store

//--- core/palette_access_pixel_select.sv
// Palette access over APB and pixel group serializer with color select
// Summary of operation
// [RULE_01] Entry written as red, green, blue bytes; blue joins them into 24 bits
// [RULE_02] Three-byte reads return red, green, blue; pointer steps after blue
// [RULE_03] Palette pointer wraps from $FF to $00 after final color cycle
// [RULE_04] Overlay pointer moves from 3 to $04 after final color cycle
// [RULE_05] Hidden modulo-three counter clears on any pointer access
// [RULE_06] Normal mode moves one 8-bit entry per cycle, stepping each cycle
// [RULE_07] Normal mode wraps $FF to $00 and overlay 3 to $04
// [RULE_08] Per-color device only acts on its own color cycle
// [RULE_09] Host enables all per-color devices together on data and pointer writes
// [RULE_10] Normal devices on 8-bit bus enabled singly; 24-bit bus together
// [RULE_11] Control register access leaves pointer unchanged, allowed any time
// [RULE_12] Invalid pointer for target discards writes, reads undefined
// [RULE_13] Writing a displayed entry disturbs at most one pixel
// [RULE_14] Load strobe rising edge captures sync, blank, indices, overlays
// [RULE_15] Group pixels output A first, one per clock, then repeat
// [RULE_16] Internal transfer strobe lags load strobe by one to four clocks
// [RULE_17] Transfer strobe moves group into second stage for multiplexing
// [RULE_18] One load edge per four or five clocks, else unlocked, resync
// [RULE_19] Index and overlay pass masking, blinking and overlay enables
// [RULE_20] Retrace is blank low for 256 loads; blink changes only then
// [RULE_21] Overlay select 00 uses palette if enabled, else overlay 0
// [RULE_22] Selected color presented to converter inputs every clock
// [RULE_23] Target select: pointer, palette, control 4 to 7, overlay 0 to 3
// [RULE_24] Read mask ANDed with index bit planes before lookup
// [RULE_25] Blink rate 16/48, 16/16, 32/32, 64/64 on/off
`timescale 1ns/1ps
module palette_access_pixel_select
    import pixsel_pkg::*;
#(
    parameter int RETRACE_LOADS = RETRACE_LOADS_DEF
)
(
    input  wire logic        pclk,                // Clock, 20 MHz
    input  wire logic        presetn,             // Async reset, low
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB write
    input  wire logic [11:0] paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    output logic      [31:0] prdata,              // APB read data
    output logic             pready,              // APB ready
    output logic             pslverr,             // APB error
    input  wire logic        group_load_strobe_n, // Group load pin
    input  wire logic [39:0] pixel_index,         // Indices A..E
    input  wire logic [9:0]  overlay_select,      // Overlays A..E
    input  wire logic        sync_n,              // Sync pin, low
    input  wire logic        blank_n,             // Blank pin, low
    output logic      [23:0] color_out,           // Converter word
    output logic             sync_out_n,          // Sync to converter
    output logic             blank_out_n          // Blank to converter
);

    // *******************************
    // Parameter check
    // *******************************
    generate
        if (RETRACE_LOADS < 1 || RETRACE_LOADS > 511)
        begin : g_bad_param
            $error("RETRACE_LOADS must lie in 1..511");
        end
    endgenerate

    localparam logic [8:0] RETRACE_CNT = 9'(RETRACE_LOADS);

    // *******************************
    // State
    // *******************************
    typedef struct packed {
        logic [7:0]       ptr;
        logic [1:0]       cnt;
        logic [7:0]       red;
        logic [7:0]       grn;
        logic [7:0]       cmd;
        logic [7:0]       rmask;
        logic [7:0]       bmask;
        logic [3:0]       test;
        logic [3:0]       cfg;
        logic [31:0]      rdata;
        logic             slverr;
        logic [2:0]       ld_s;
        logic [GRP_W-1:0] in_s1;
        logic [GRP_W-1:0] in_s2;
        logic [GRP_W-1:0] cap;
        logic [GRP_W-1:0] grp;
        logic             xfer;
        logic [2:0]       slot;
        logic [2:0]       gap;
        logic             locked;
        logic [8:0]       blank_cnt;
        logic             retrace;
        logic [6:0]       frames;
        logic             blink_off;
        logic [23:0]      color;
        logic             sync_n;
        logic             blank_n;
    } state_s;

    localparam state_s RST_STATE = '{
        cmd     : RST_CMD,
        rmask   : RST_RMASK,
        cfg     : RST_CFG,
        ld_s    : 3'h7,
        sync_n  : 1'b1,
        blank_n : 1'b1,
        default : '0
    };

    state_s r;
    state_s next_r;

    color_mem_if mem ();

    // Color store instance
    color_store u_store
    (
        .clk (pclk),
        .m   (mem)
    );

    // *******************************
    // Bus decode
    // *******************************
    logic       setup;
    logic       access;
    logic       mapped;
    logic       is_cfg;
    logic [1:0] tgt;
    mode_e      mode;
    logic [1:0] color_id;
    logic       ctl_ok;
    logic       valid;
    logic       mine;
    logic       last;
    logic       color_acc;
    logic [1:0] lane;
    logic [7:0] host_byte;
    logic       edge_seen;
    logic [2:0] slot_last;
    logic [2:0] group_len;

    // Phase, target and pointer validity
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign mapped    = paddr[11:5] == 7'h00 && (!paddr[4] || paddr[3:2] == 2'h0);
    assign is_cfg    = paddr[4];
    assign tgt       = paddr[3:2];                                    // [RULE_23]
    assign mode      = mode_e'(r.cfg[1:0]);
    assign color_id  = r.cfg[3:2];
    assign ctl_ok    = r.ptr[7:2] == PTR_OVL_AFTER[7:2];              // [RULE_23]
    assign valid     = tgt == TGT_PALETTE || r.ptr[7:2] == 6'h00;     // [RULE_12]
    assign mine      = mode != MODE_PERCOLOR || r.cnt == color_id;    // [RULE_08]
    assign last      = mode == MODE_NORMAL || r.cnt == CNT_BLUE;      // [RULE_02]
    assign color_acc = access & mapped & ~is_cfg & tgt[0];
    assign lane      = (mode == MODE_TRIPLE) ? r.cnt : color_id;

    // Host byte picked from the addressed entry
    always_comb
    begin
        host_byte = 8'h00;
        unique case (lane)
            2'h0:    host_byte = mem.hdata[23:16];
            2'h1:    host_byte = mem.hdata[15:8];
            default: host_byte = mem.hdata[7:0];
        endcase
    end

    // Store write port; single clock write keeps display upset to one pixel
    assign mem.addr  = r.ptr;
    assign mem.ovl   = tgt[1];
    assign mem.we    = color_acc & pwrite & valid & mine               // [RULE_12]
                     & (mode != MODE_TRIPLE || r.cnt == CNT_BLUE);     // [RULE_01] [RULE_13]
    assign mem.wmask = (mode == MODE_TRIPLE) ? 3'h7 : (3'h4 >> color_id);
    assign mem.wdata = (mode == MODE_TRIPLE) ? {r.red, r.grn, pwdata[7:0]} // [RULE_01]
                                             : {3{pwdata[7:0]}};

    // APB answers
    assign pready  = access;
    assign pslverr = r.slverr & access;
    assign prdata  = r.rdata;

    // *******************************
    // Pixel path
    // *******************************
    logic [7:0] pix;
    logic [1:0] ol;
    logic [1:0] ol_eff;
    logic       blink_on;

    // Current slot of the second stage, masked and blinked
    assign pix    = r.grp[int'(r.slot) * PIX_W +: PIX_W];              // [RULE_15]
    assign ol     = r.grp[GRP_OVL_LO + int'(r.slot) * OVL_W +: OVL_W];
    assign ol_eff = ol & r.cmd[CMD_OL_EN +: 2]                         // [RULE_19]
                  & ~(r.cmd[CMD_OL_BLINK +: 2] & {2{r.blink_off}});
    assign mem.pix_idx = pix & r.rmask & ~(r.bmask & {8{r.blink_off}}); // [RULE_24] [RULE_19]
    assign mem.ovl_idx = ol_eff;

    // Load edge from the synchronized strobe
    assign edge_seen = r.ld_s[1] & ~r.ld_s[2];
    assign group_len = r.cmd[CMD_MUX5] ? GROUP_5_CYCLES : GROUP_4_CYCLES;
    assign slot_last = group_len - 3'h1;

    // Blink phase from the frame count
    always_comb
    begin
        blink_on = 1'b1;
        unique case (r.cmd[CMD_RATE_LO +: 2])                          // [RULE_25]
            2'h0:    blink_on = r.frames[5:4] == 2'h0;
            2'h1:    blink_on = ~r.frames[4];
            2'h2:    blink_on = ~r.frames[5];
            default: blink_on = ~r.frames[6];
        endcase
    end

    // *******************************
    // Next state
    // *******************************
    always_comb
    begin
        next_r = r;

        // Read data prepared in the setup phase
        if (setup)
        begin
            next_r.slverr = ~mapped;
            next_r.rdata  = 32'h0000_0000;
            if (mapped && is_cfg)
                next_r.rdata = {26'h0, r.locked, r.retrace, r.cfg};
            else if (mapped)
            begin
                unique case (tgt)
                    TGT_POINTER: next_r.rdata = {24'h0, r.ptr};
                    TGT_CONTROL:
                    begin
                        if (ctl_ok)
                        begin
                            unique case (r.ptr[1:0])
                                2'h0:    next_r.rdata = {24'h0, r.rmask};
                                2'h1:    next_r.rdata = {24'h0, r.bmask};
                                2'h2:    next_r.rdata = {24'h0, r.cmd};
                                default: next_r.rdata = {28'h0, r.test};
                            endcase
                        end
                    end
                    default:
                    begin
                        if (valid && mine)
                            next_r.rdata = {24'h0, host_byte};          // [RULE_02]
                    end
                endcase
            end
        end

        // Side effects at the access phase
        if (access && mapped)
        begin
            if (is_cfg)
            begin
                if (pwrite)
                    next_r.cfg = pwdata[3:0];
            end
            else
            begin
                unique case (tgt)
                    TGT_POINTER:
                    begin
                        if (pwrite)
                            next_r.ptr = pwdata[7:0];
                        next_r.cnt = CNT_RED;                           // [RULE_05]
                    end
                    TGT_CONTROL:
                    begin
                        // Pointer kept for read-modify-write
                        if (pwrite && ctl_ok)                           // [RULE_11]
                        begin
                            unique case (r.ptr[1:0])
                                2'h0:    next_r.rmask = pwdata[7:0];
                                2'h1:    next_r.bmask = pwdata[7:0];
                                2'h2:    next_r.cmd   = pwdata[7:0];
                                default: next_r.test  = pwdata[3:0];
                            endcase
                        end
                    end
                    default:
                    begin
                        // Red and green held until the blue cycle
                        if (pwrite && valid && mode == MODE_TRIPLE)     // [RULE_01]
                        begin
                            if (r.cnt == 2'h0)
                                next_r.red = pwdata[7:0];
                            if (r.cnt == 2'h1)
                                next_r.grn = pwdata[7:0];
                        end
                        if (mode != MODE_NORMAL)                        // [RULE_05] [RULE_09]
                            next_r.cnt = (r.cnt == CNT_BLUE) ? CNT_RED : r.cnt + 2'h1;
                        // Plain 8-bit step wraps $FF to $00, overlay 3 to $04
                        if (last)                                       // [RULE_03] [RULE_04]
                            next_r.ptr = r.ptr + 8'h01;                 // [RULE_06] [RULE_07]
                    end
                endcase
            end
        end

        // Pin synchronizers; stage one feeds only stage two
        next_r.ld_s  = {r.ld_s[1:0], group_load_strobe_n};
        next_r.in_s1 = {sync_n, blank_n, overlay_select, pixel_index};
        next_r.in_s2 = r.in_s1;

        // Group capture, transfer and lock tracking
        next_r.xfer = edge_seen;                                        // [RULE_16]
        if (edge_seen)
        begin
            next_r.cap    = r.in_s2;                                    // [RULE_14]
            next_r.gap    = 3'h0;
            next_r.locked = (r.gap + 3'h1) == group_len;                // [RULE_18]
            if (r.in_s2[GRP_BLANK])
                next_r.blank_cnt = 9'h000;
            else if (r.blank_cnt != RETRACE_CNT)
                next_r.blank_cnt = r.blank_cnt + 9'h001;                // [RULE_20]
            if (!r.in_s2[GRP_BLANK] && r.blank_cnt == RETRACE_CNT - 9'h001)
                next_r.frames = r.frames + 7'h01;
        end
        else if (r.gap != 3'h7)
            next_r.gap = r.gap + 3'h1;
        next_r.retrace = r.blank_cnt == RETRACE_CNT;                    // [RULE_20]

        // Second stage loads on transfer; slot restarts at A
        if (r.xfer)
        begin
            next_r.grp  = r.cap;                                        // [RULE_17]
            next_r.slot = 3'h0;                                         // [RULE_18]
        end
        else
            next_r.slot = (r.slot >= slot_last) ? 3'h0 : r.slot + 3'h1; // [RULE_15]

        // Blink state moves only during retrace
        if (r.retrace)
            next_r.blink_off = ~blink_on;                               // [RULE_20]

        // Palette or overlay choice per clock
        next_r.color = (ol_eff == 2'h0 && r.cmd[CMD_PAL_EN])            // [RULE_21]
                     ? mem.pix_data : mem.ovl_data;                     // [RULE_22]
        next_r.sync_n  = r.grp[GRP_SYNC];
        next_r.blank_n = r.grp[GRP_BLANK];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= RST_STATE;
        else
            r <= next_r;
    end

    // Converter outputs
    assign color_out   = r.color;
    assign sync_out_n  = r.sync_n;
    assign blank_out_n = r.blank_n;

    // *******************************
    // Assertions
    // *******************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_pal_wrap: assert property (color_acc && !tgt[1] && last && r.ptr == PTR_PAL_LAST // [RULE_03]
        |=> r.ptr == PTR_PAL_FIRST) else $error("palette pointer did not wrap");
    a_ovl_step: assert property (color_acc && tgt[1] && last && r.ptr == PTR_OVL_LAST // [RULE_04]
        |=> r.ptr == PTR_OVL_AFTER) else $error("overlay pointer did not step to 4");
    a_cnt_clear: assert property (access && mapped && !is_cfg && tgt == TGT_POINTER // [RULE_05]
        |=> r.cnt == CNT_RED) else $error("color counter not cleared");
    a_ctl_hold: assert property (access && mapped && !is_cfg && tgt == TGT_CONTROL // [RULE_11]
        |=> $stable(r.ptr)) else $error("pointer moved on control access");
    a_triple_wait: assert property (color_acc && mode == MODE_TRIPLE && r.cnt != CNT_BLUE // [RULE_01]
        |-> !mem.we) else $error("entry written before blue cycle");
    a_invalid_drop: assert property (color_acc && !valid |-> !mem.we) // [RULE_12]
        else $error("write to invalid entry");
    a_normal_step: assert property (color_acc && mode == MODE_NORMAL // [RULE_06]
        |=> r.ptr == $past(r.ptr) + 8'h01) else $error("normal mode did not step");
    a_xfer_lag: assert property ($rose(r.ld_s[1]) |=> r.xfer ##1 !r.xfer) // [RULE_16]
        else $error("transfer strobe late or long");
    a_slot_start: assert property (r.xfer |=> r.slot == 3'h0 ##1 (r.xfer || r.slot == 3'h1)) // [RULE_15]
        else $error("slot sequence did not start at A");
    a_blink_still: assert property (!r.retrace |=> $stable(r.blink_off)) // [RULE_20]
        else $error("blink changed outside retrace");

endmodule : palette_access_pixel_select

//--- bench/frame_source.sv
// Frame buffer model: load strobe and pixel groups
`timescale 1ns/1ps
module frame_source
(
    input  wire logic [7:0]  base,    // Slot A index
    input  wire logic [1:0]  ovl,     // Overlay of all slots
    output logic             ld_n,    // Load strobe
    output logic      [39:0] idx,     // Group indices
    output logic      [9:0]  ovl_grp  // Group overlays
);
    // 400 ns strobe, off phase; data moves on the falling edge only
    initial
    begin
        ld_n = 1'b0;
        #13;
        forever
        begin
            ld_n = 1'b0;
            for (int k = 0; k < 5; k++)
            begin
                idx[8*k+:8]     = base + 8'(k);
                ovl_grp[2*k+:2] = ovl;
            end
            #200;
            ld_n = 1'b1;
            #200;
        end
    end
endmodule : frame_source

//--- bench/tb_palette_access_pixel_select.sv
// Self-checking bench for palette access and pixel select
`timescale 1ns/1ps
module tb_palette_access_pixel_select
    import pixsel_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ld_n;
    logic        blank_pin, sync_out_n, blank_out_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [39:0] idx;
    logic [9:0]  ovl_grp;
    logic [23:0] color_out;
    logic [7:0]  base;
    logic [1:0]  ovl;
    int          n_mismatch, check_count, cyc;

    palette_access_pixel_select #(.RETRACE_LOADS(4)) palette_access_pixel_select_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .group_load_strobe_n(ld_n), .pixel_index(idx),
        .overlay_select(ovl_grp), .sync_n(blank_pin), .blank_n(blank_pin),
        .color_out(color_out), .sync_out_n(sync_out_n), .blank_out_n(blank_out_n));
    frame_source frame_source_inst (.base(base), .ovl(ovl), .ld_n(ld_n), .idx(idx),
        .ovl_grp(ovl_grp));

    // Clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    function automatic logic [23:0] ent(input logic [7:0] i);
        return {i, ~i, i ^ 8'h3c};
    endfunction : ent

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr3(input logic [11:0] a, input logic [23:0] v);
        for (int k = 2; k >= 0; k--)
            apb(1'b1, a, 32'(v[8*k+:8]));
    endtask : wr3

    task automatic ptr_chk(input logic [7:0] e);
        apb(1'b0, OFS_POINTER, 0);
        chk("pointer", 32'(e), rd);
    endtask : ptr_chk

    task automatic seq(input logic [7:0] b);
        for (int n = 0; n < 40 && color_out !== ent(b); n++)
            @(negedge pclk);
        for (int k = 0; k < 4; k++)
        begin
            chk("color", 32'(ent(b + 8'(k))), 32'(color_out));
            @(negedge pclk);
        end
    endtask : seq

    task automatic t_regs;
        ptr_chk(8'h00);
        apb(1'b1, OFS_POINTER, 6);
        apb(1'b0, OFS_CONTROL, 0);
        chk("command", 32'(RST_CMD), rd);
        apb(1'b1, OFS_POINTER, 4);
        apb(1'b1, OFS_CONTROL, 32'h0000_00a5);
        apb(1'b0, OFS_CONTROL, 0);
        chk("read mask", 32'h0000_00a5, rd);
        ptr_chk(8'h04);
        apb(1'b1, OFS_CONTROL, 32'h0000_00ff);
        apb(1'b1, 12'h020, 0);
        chk("slverr", 1, 32'(err));
        $display("regs done");
    endtask : t_regs

    task automatic t_wrap;
        apb(1'b1, OFS_POINTER, 32'h0000_00ff);
        wr3(OFS_PALETTE, ent(8'hff));
        ptr_chk(8'h00);
        apb(1'b1, OFS_POINTER, 32'h0000_00ff);
        for (int k = 2; k >= 0; k--)
        begin
            apb(1'b0, OFS_PALETTE, 0);
            chk("byte", 32'(ent(8'hff) >> (8 * k)) & 32'h0000_00ff, rd);
        end
        ptr_chk(8'h00);
        $display("wrap done");
    endtask : t_wrap

    task automatic t_overlay;
        apb(1'b1, OFS_POINTER, 1);
        wr3(OFS_OVERLAY, 24'h99_8877);
        apb(1'b1, OFS_POINTER, 3);
        wr3(OFS_OVERLAY, ent(8'h03));
        ptr_chk(8'h04);
        apb(1'b1, OFS_POINTER, 1);
        apb(1'b1, OFS_OVERLAY, 32'h0000_0011);
        apb(1'b1, OFS_POINTER, 1);
        wr3(OFS_OVERLAY, 24'h12_3456);
        ovl <= 2'h1;
        repeat (30) @(negedge pclk);
        chk("overlay", 32'h0012_3456, 32'(color_out));
        ovl <= 2'h0;
        $display("overlay done");
    endtask : t_overlay

    task automatic t_pixels;
        apb(1'b1, OFS_POINTER, 0);
        for (int i = 0; i < 8; i++)
            wr3(OFS_PALETTE, ent(8'(i)));
        base <= 8'h04;
        seq(8'h04);
        apb(1'b1, OFS_POINTER, 4);
        apb(1'b1, OFS_CONTROL, 3);
        seq(8'h00);
        apb(1'b1, OFS_CONFIG, 1);
        apb(1'b1, OFS_POINTER, 32'h0000_00ff);
        apb(1'b1, OFS_PALETTE, 32'h0000_0077);
        ptr_chk(8'h00);
        apb(1'b1, OFS_POINTER, 32'h0000_00ff);
        apb(1'b0, OFS_PALETTE, 0);
        chk("normal byte", 32'h0000_0077, rd);
        $display("pixels done");
    endtask : t_pixels

    // Green-only device on a shared bus: other color cycles act on nothing
    task automatic t_percolor;
        apb(1'b1, OFS_CONFIG, 6);
        apb(1'b1, OFS_POINTER, 2);
        wr3(OFS_PALETTE, 24'h11_2233);
        apb(1'b1, OFS_POINTER, 2);
        for (int k = 2; k >= 0; k--)
        begin
            apb(1'b0, OFS_PALETTE, 0);
            chk("own color", (k == 1) ? 32'h0000_0022 : 32'h0000_0000, rd);
        end
        apb(1'b1, OFS_CONFIG, 0);
        ptr_chk(8'h03);
        $display("per-color done");
    endtask : t_percolor

    // Blank held low: outputs follow per group, retrace flag rises
    task automatic t_blank;
        blank_pin <= 1'b0;
        repeat (60) @(negedge pclk);
        chk("blank out", 32'h0, 32'(blank_out_n));
        chk("sync out", 32'h0, 32'(sync_out_n));
        apb(1'b0, OFS_CONFIG, 0);
        chk("retrace", 32'h0000_0010, rd);
        blank_pin <= 1'b1;
        repeat (30) @(negedge pclk);
        chk("blank out", 32'h1, 32'(blank_out_n));
        $display("blank done");
    endtask : t_blank

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Reset for 10 cycles, then the scenarios
    initial
    begin
        {psel, penable, pwrite, presetn, blank_pin} = 5'h01;
        paddr = 12'h000;
        pwdata = 32'h0;
        base = 8'h00;
        ovl = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_wrap();
        t_overlay();
        t_pixels();
        t_percolor();
        t_blank();
        final_report();
    end
endmodule : tb_palette_access_pixel_select
